/* shared/bus_addr_map.vh */
`ifndef BUS_ADDR_MAP_VH
`define BUS_ADDR_MAP_VH
// apb register offsets (byte addresses)
`define OFF_SETUP 12'h000
`define OFF_RATE 12'h004
`define OFF_STATUS 12'h008
`define OFF_CMD 12'h00c
`define OFF_MANUAL_TRIGGER_INPUT 12'h010
// setting values
`define ADDR_DEFAULT 6'h1b
`define ADDR_MAX 6'h1e
`define SET_TALK_PREFIX 6'h28
`define SET_TALK_PLAIN 6'h29
// bus command bytes
`define LISTEN_BASE 8'h20
`define LISTEN_LAST 8'h3f
`define TALK_BASE 8'h40
`define TALK_LAST 8'h5f
`define UNLISTEN 8'h3f
`define UNTALK 8'h5f
// rate codes
`define RATE_CONV 3'h0
`define RATE_MANUAL 3'h6
// times
`define CLK_HZ 10000000
`define CONV_MS 360
`define CONV_CYC ((`CLK_HZ / 1000) * `CONV_MS)
`define SEC_CYC `CLK_HZ
// seconds between readings for rate codes 1 to 5
`define SEC_RATE1 12'h001
`define SEC_RATE2 12'h00a
`define SEC_RATE3 12'h03c
`define SEC_RATE4 12'h258
`define SEC_RATE5 12'he10
// status bit positions
`define ST_TALK_ONLY 0
`define ST_LISTEN 1
`define ST_TALK 2
`define ST_PREFIX 3
`endif

/* rtl/bus_address_and_talk_only_unit.v */
// Our own choices: register access over APB and the address map.
`include "bus_addr_map.vh"
module bus_address_and_talk_only_unit #(
    parameter CONV_CYCLES = `CONV_CYC,
    parameter SEC_CYCLES = `SEC_CYC
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire pready_o,
    output reg [31:0] prdata_o,
    output wire pslverr_o,
    // non-volatile setting store
    input wire nv_valid_i,
    input wire [5:0] nv_setting_i,
    output reg nv_write_o,
    output reg [5:0] nv_setting_o,
    // instrument bus command bytes
    input wire cmd_valid_i,
    input wire [7:0] cmd_byte_i,
    input wire cmd_atn_i,
    output reg cmd_accept_o,
    // readings
    input wire reading_ready_i,
    input wire manual_trigger_input_i,
    output wire send_reading_o,
    output wire send_prefix_o,
    output wire talk_indicator_o,
    output wire listen_o,
    output wire talk_o
);
    reg [5:0] setting_q;
    reg [5:0] pending_q;
    reg loaded_q;
    reg [2:0] rate_q;
    reg listen_q;
    reg talk_q;
    reg [31:0] tick_q;
    reg [11:0] sec_q;
    reg due_q;
    reg manual_trigger_input_q;
    reg send_q;
    wire [5:0] wsetting = pwdata_i[5:0];
    wire wr = psel_i & penable_i & pwrite_i;
    wire valid_set = (wsetting <= `ADDR_MAX) || (wsetting == `SET_TALK_PREFIX)
        || (wsetting == `SET_TALK_PLAIN);
    wire talk_only = (setting_q == `SET_TALK_PREFIX) || (setting_q == `SET_TALK_PLAIN);
    wire [4:0] my_addr = setting_q[4:0];
    reg [11:0] sec_len;
    wire tick_end = (tick_q == 32'h0);

    assign pready_o = 1'b1;
    assign pslverr_o = 1'b0;
    assign talk_indicator_o = talk_only;
    assign listen_o = listen_q;
    assign talk_o = talk_q;
    assign send_prefix_o = (setting_q == `SET_TALK_PREFIX);
    // readings only leave while talker or talk-only
    assign send_reading_o = send_q & (talk_q | talk_only);

    // seconds per reading for codes 1..5
    // codes 0 and 6 never reach the seconds counter, any value will do
    always @*
    begin
        case (rate_q)
            3'h1:
            begin
                sec_len = `SEC_RATE1;
            end
            3'h2:
            begin
                sec_len = `SEC_RATE2;
            end
            3'h3:
            begin
                sec_len = `SEC_RATE3;
            end
            3'h4:
            begin
                sec_len = `SEC_RATE4;
            end
            3'h5:
            begin
                sec_len = `SEC_RATE5;
            end
            default:
            begin
                sec_len = `SEC_RATE1;
            end
        endcase
    end

    // setting store, pending value applied only at setup exit
    always @(posedge clk_i)
    begin
        nv_write_o <= 1'b0;
        if (!rst_n_i)
        begin
            setting_q <= `ADDR_DEFAULT;
            pending_q <= `ADDR_DEFAULT;
            loaded_q <= 1'b0;
            rate_q <= `RATE_CONV;
            nv_setting_o <= `ADDR_DEFAULT;
        end
        else
        begin
            if (!loaded_q && nv_valid_i)
            begin
                loaded_q <= 1'b1;
                // a corrupt stored value falls back to the default
                if ((nv_setting_i <= `ADDR_MAX) || (nv_setting_i == `SET_TALK_PREFIX)
                    || (nv_setting_i == `SET_TALK_PLAIN))
                begin
                    setting_q <= nv_setting_i;
                    pending_q <= nv_setting_i;
                end
            end
            if (wr && paddr_i == `OFF_SETUP && valid_set)
                pending_q <= wsetting;
            if (wr && paddr_i == `OFF_RATE && pwdata_i[2:0] <= `RATE_MANUAL)
                rate_q <= pwdata_i[2:0];
            if (wr && paddr_i == `OFF_CMD && pwdata_i[0])
            begin
                setting_q <= pending_q;
                nv_setting_o <= pending_q;
                nv_write_o <= 1'b1;
            end
        end
    end

    // listener and talker state
    always @(posedge clk_i)
    begin
        cmd_accept_o <= 1'b0;
        if (!rst_n_i)
        begin
            listen_q <= 1'b0;
            talk_q <= 1'b0;
        end
        else if (talk_only)
        begin
            listen_q <= 1'b0;
            talk_q <= 1'b0;
        end
        else if (cmd_valid_i && cmd_atn_i)
        begin
            if (cmd_byte_i == `UNLISTEN)
                listen_q <= 1'b0;
            else if (cmd_byte_i >= `LISTEN_BASE && cmd_byte_i < `LISTEN_LAST
                && cmd_byte_i[4:0] == my_addr)
            begin
                listen_q <= 1'b1;
                talk_q <= 1'b0;
            end
            else if (cmd_byte_i == `UNTALK)
                talk_q <= 1'b0;
            else if (cmd_byte_i >= `TALK_BASE && cmd_byte_i < `TALK_LAST)
            begin
                talk_q <= (cmd_byte_i[4:0] == my_addr);
                if (cmd_byte_i[4:0] == my_addr)
                    listen_q <= 1'b0;
            end
        end
        else if (cmd_valid_i && listen_q)
            cmd_accept_o <= 1'b1;
    end

    // talk-only pacing
    always @(posedge clk_i)
    begin
        send_q <= 1'b0;
        if (!rst_n_i)
        begin
            tick_q <= 32'h0;
            sec_q <= 12'h0;
            due_q <= 1'b0;
            manual_trigger_input_q <= 1'b0;
        end
        else
        begin
            manual_trigger_input_q <= manual_trigger_input_i;
            if (!talk_only)
            begin
                tick_q <= 32'h0;
                sec_q <= 12'h0;
                due_q <= 1'b0;
                send_q <= reading_ready_i;
            end
            else if (rate_q == `RATE_MANUAL)
            begin
                // one reading per trigger edge
                if (manual_trigger_input_i && !manual_trigger_input_q)
                    due_q <= 1'b1;
                if (due_q && reading_ready_i)
                begin
                    send_q <= 1'b1;
                    due_q <= 1'b0;
                end
            end
            else if (rate_q == `RATE_CONV)
                send_q <= reading_ready_i;
            else
            begin
                // due flag waits for the next finished reading
                // so a reading is never cut short; the seconds count runs on through a send, so two sends can fall closer than the interval
                tick_q <= tick_end ? SEC_CYCLES - 1 : tick_q - 32'h1;
                if (tick_end)
                begin
                    if (sec_q + 12'h1 >= sec_len)
                    begin
                        sec_q <= 12'h0;
                        due_q <= 1'b1;
                    end
                    else
                        sec_q <= sec_q + 12'h1;
                end
                if (due_q && reading_ready_i)
                begin
                    send_q <= 1'b1;
                    due_q <= 1'b0;
                end
            end
        end
    end

    // apb read mux
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
            prdata_o <= 32'h0;
        else if (psel_i && !penable_i && !pwrite_i)
        begin
            case (paddr_i)
                `OFF_SETUP: prdata_o <= {26'h0, setting_q};
                `OFF_RATE: prdata_o <= {29'h0, rate_q};
                `OFF_STATUS: prdata_o <= {28'h0, send_prefix_o, talk_q, listen_q, talk_only};
                `OFF_CMD: prdata_o <= {26'h0, pending_q};
                default: prdata_o <= 32'h0;
            endcase
        end
    end
endmodule

/* test/bus_addr_props.sv */
module bus_addr_props (
    // watched ports
    input wire clk_i,
    input wire rst_n_i,
    input wire cmd_valid_i,
    input wire [7:0] cmd_byte_i,
    input wire cmd_atn_i,
    input wire cmd_accept_o,
    input wire reading_ready_i,
    input wire send_reading_o,
    input wire talk_indicator_o,
    input wire listen_o,
    input wire talk_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    wire cmd = cmd_valid_i && cmd_atn_i && !talk_indicator_o;
    a_accept_needs_listen: assert property (cmd_accept_o |-> $past(listen_o && cmd_valid_i))
        else $error("data byte accepted while not listener");
    a_send_needs_talk: assert property (send_reading_o |-> talk_o || talk_indicator_o)
        else $error("reading sent while not talker");
    a_addressed_send: assert property (reading_ready_i && talk_o && !cmd_valid_i
        && !talk_indicator_o |=> send_reading_o) else $error("addressed reading not sent");
    a_listen_from_cmd: assert property ($rose(listen_o) |-> $past(cmd && cmd_byte_i[7:5] == 3'h1))
        else $error("listen without listen address");
    a_talk_from_cmd: assert property ($rose(talk_o) |-> $past(cmd && cmd_byte_i[7:5] == 3'h2))
        else $error("talk without talk address");
    a_untalk_release: assert property (cmd && cmd_byte_i == 8'h5f |=> !talk_o)
        else $error("untalk did not release talker");
    a_roles_exclusive: assert property (!(listen_o && talk_o))
        else $error("listener and talker at once");
    a_talk_only_deaf: assert property (talk_indicator_o && cmd_valid_i
        |=> $stable(listen_o) && $stable(talk_o)) else $error("command obeyed in talk-only");
endmodule
bind bus_address_and_talk_only_unit bus_addr_props bus_addr_props_i (.clk_i, .rst_n_i,
    .cmd_valid_i, .cmd_byte_i, .cmd_atn_i, .cmd_accept_o, .reading_ready_i, .send_reading_o,
    .talk_indicator_o, .listen_o, .talk_o);

/* test/bus_ctrl_model.sv */
module bus_ctrl_model (
    input wire clk_i,
    output logic valid_o = 1'b0,
    output logic [7:0] byte_o = 8'h00,
    output logic atn_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // one byte per valid pulse; a released bus never shows the old byte
    task send(input logic atn, input logic [7:0] b);
        valid_o <= 1'b1;
        byte_o <= b;
        atn_o <= atn;
        @(posedge clk_i);
        valid_o <= 1'b0;
        byte_o <= ~b;
        repeat (2) @(posedge clk_i);
    endtask
endmodule

/* test/bus_address_and_talk_only_unit_tb.sv */
module bus_address_and_talk_only_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic reading_ready_i = 1'b0;
    logic manual_trigger_input = 1'b0;
    wire pready_o, pslverr_o, nv_write_o, cmd_valid_i, cmd_atn_i, cmd_accept_o, talk_o;
    wire send_reading_o, send_prefix_o, talk_indicator_o, listen_o;
    wire [31:0] prdata_o;
    wire [5:0] nv_setting_o;
    wire [7:0] cmd_byte_i;
    int errors = 0;
    int comparisons = 0;
    int sent = 0;
    int accepted = 0;
    int stored = 0;
    int n;
    logic [31:0] q;
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i)
        if (send_reading_o === 1'b1)
            sent <= sent + 1;
    always @(posedge clk_i)
        if (cmd_accept_o === 1'b1)
            accepted <= accepted + 1;
    always @(posedge clk_i)
        if (nv_write_o === 1'b1)
            stored <= stored + 1;
    bus_address_and_talk_only_unit #(.SEC_CYCLES(10)) bus_address_and_talk_only_unit_i (
        .clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
        .prdata_o, .pslverr_o, .nv_valid_i(1'b0), .nv_setting_i(6'h00), .nv_write_o,
        .nv_setting_o, .cmd_valid_i, .cmd_byte_i, .cmd_atn_i, .cmd_accept_o, .reading_ready_i,
        .manual_trigger_input_i(manual_trigger_input), .send_reading_o, .send_prefix_o, .talk_indicator_o,
        .listen_o, .talk_o);
    bus_ctrl_model bus_ctrl_model_i (.clk_i, .valid_o(cmd_valid_i), .byte_o(cmd_byte_i),
        .atn_o(cmd_atn_i));
    task end_sim;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 50);
        q = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
        if (k == 50)
        begin
            errors++;
            end_sim();
        end
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] e, input string s);
        acc(1'b0, a, 32'h0);
        chk(s, e, q);
    endtask
    // setup value only becomes active on the exit command
    task setup(input logic [5:0] v);
        acc(1'b1, 12'h000, {26'h0, v});
        acc(1'b1, 12'h00c, 32'h1);
    endtask
    task rdy(input int k);
        @(posedge clk_i);
        reading_ready_i <= 1'b1;
        @(posedge clk_i);
        reading_ready_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("reading count", n + k, sent);
    endtask
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdchk(12'h000, 32'd27, "setup");
        bus_ctrl_model_i.send(1'b1, 8'h3f);
        bus_ctrl_model_i.send(1'b1, 8'h3b);
        rdchk(12'h008, 32'h2, "status");
        bus_ctrl_model_i.send(1'b0, 8'h46);
        chk("accepted", 1, accepted);
        bus_ctrl_model_i.send(1'b1, 8'h5b);
        rdchk(12'h008, 32'h4, "status");
        n = sent;
        rdy(1);
        bus_ctrl_model_i.send(1'b1, 8'h3b);
        rdchk(12'h008, 32'h2, "status");
        rdy(1);
        $display("test addressing done");
        acc(1'b1, 12'h000, 32'd30);
        rdchk(12'h000, 32'd27, "setup");
        for (int a = 0; a <= 30; a += 30)
        begin
            setup(a);
            chk("stored", a, nv_setting_o);
            bus_ctrl_model_i.send(1'b1, 8'h3f);
            bus_ctrl_model_i.send(1'b1, 8'h20 + a);
            rdchk(12'h008, 32'h2, "status");
        end
        chk("nv writes", 2, stored);
        setup(6'd31);
        setup(6'd42);
        rdchk(12'h000, 32'd30, "setup");
        bus_ctrl_model_i.send(1'b1, 8'h3f);
        $display("test address setting done");
        for (int s = 40; s <= 41; s++)
        begin
            setup(s);
            rdchk(12'h008, {28'h0, s == 40, 3'h1}, "status");
            chk("prefix", s == 40, send_prefix_o);
            chk("talk lamp", 1, talk_indicator_o);
            bus_ctrl_model_i.send(1'b1, 8'h3e);
            rdchk(12'h008, {28'h0, s == 40, 3'h1}, "status");
            n = sent;
            rdy(1);
        end
        $display("test talk-only done");
        acc(1'b1, 12'h004, 32'h6);
        n = sent;
        rdy(0);
        manual_trigger_input <= 1'b1;
        rdy(1);
        rdy(1);
        manual_trigger_input <= 1'b0;
        acc(1'b1, 12'h004, 32'h1);
        n = sent;
        rdy(1);
        rdy(1);
        rdy(2);
        setup(6'd27);
        chk("talk lamp", 0, talk_indicator_o);
        $display("test trigger done");
        end_sim();
    end
endmodule
